/* File: core/sdc_pkg.sv */
// Constants, types and field layout of the shared disk command port
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// R1: Arbiter serves eight host ports; four drives are selectable.
// R2: Rotating scheme: priority of ports 0-7 rotates after each transaction.
// R3: Modified scheme: port 0 always wins, ports 1-7 rotate.
// R4: Fixed scheme: port 0 highest, port 7 lowest, never changes.
// R5: Outgoing bytes get odd parity, rechecked after the buffer stage.
// R6: Bytes read from disk carry odd parity, checked on reception.
// R7: Token bit loaded at command start, shifts with every byte.
// R8: Token checked at each sector end; absence is a byte count error.
// R9: Write parity or count error flags sector; read parity flags read.
// R10: Data moves by cycle stealing; done pulse after whole transfer.
// R11: Command block sits at memory 0810 through 0815.
// R12: First data byte at origin plus 4; fields sit at origin 1 to 3.
// R13: Progress pair set at start, then holds last address moved; code writes it only after each byte, not at start.
// R14: Transfer stops at the terminating address, reads and writes.
// R15: Host issues no command while busy.
// R16: Bits 7:6 of the mode byte pick drive 0 to 3.
// R17: Addressing a drive that is not ready sets the not-ready flag.
// R18: Bits 5:4 pick removable or fixed platter 0, 1 or 2.
// R19: Opcode 0001 reads; any bad sector check sets read error.
// R20: Opcode 0010 writes; the disk side appends a check per sector.
// R21: Opcode 0100 verifies like a read without storing to memory.
// R22: Status bit 7 idle: cleared at start, set at end or abort.
// R23: Status bits 6 and 4 set on missing sector, write parity, count.
// R24: Status bit 5 set at read or verify end on check or parity fail.
// R25: A granted port keeps its grant until its transaction ends.
package sdc_pkg;

    //------------------------------------------------------------------
    // Command block
    //------------------------------------------------------------------
    localparam logic [15:0] ADDR_ORIGIN_LO = 16'h0810;
    localparam logic [15:0] ADDR_ORIGIN_HI = 16'h0811;
    localparam logic [15:0] ADDR_PROG_LO   = 16'h0812;
    localparam logic [15:0] ADDR_PROG_HI   = 16'h0813;
    localparam logic [15:0] ADDR_END_LO    = 16'h0814;
    localparam logic [15:0] ADDR_END_HI    = 16'h0815;
    localparam logic [15:0] OFS_MODE       = 16'h0001;
    localparam logic [15:0] OFS_DATA       = 16'h0004;

    //------------------------------------------------------------------
    // Mode byte fields, opcodes, status bits
    //------------------------------------------------------------------
    localparam int DRV_HI = 7;
    localparam int DRV_LO = 6;
    localparam int PLT_HI = 5;
    localparam int PLT_LO = 4;
    localparam logic [3:0] OP_READ   = 4'h1;
    localparam logic [3:0] OP_WRITE  = 4'h2;
    localparam logic [3:0] OP_VERIFY = 4'h4;
    localparam int ST_IDLE   = 7;
    localparam int ST_SECTOR = 6;
    localparam int ST_READ   = 5;
    localparam int ST_ADDR   = 4;
    localparam int ST_NRDY   = 1;
    localparam logic [7:0] STATUS_RESET = 8'h80;

    //------------------------------------------------------------------
    // Sizes
    //------------------------------------------------------------------
    localparam int NPORT      = 8;
    localparam int SECT_BYTES = 256;
    localparam logic [7:0] SECT_LAST = 8'hFF;
    localparam logic [2:0] OWN_PORT  = 3'h0;

    typedef enum logic [1:0] {
        SCH_ROTATE, SCH_MODIFIED, SCH_FIXED, SCH_SPARE
    } sdc_scheme_t;

    typedef enum logic [1:0] {
        PLT_REMOVABLE, PLT_FIXED1, PLT_FIXED0, PLT_FIXED2
    } sdc_platter_t;

    typedef struct packed {
        logic       par;
        logic [7:0] data;
    } sdc_pbyte_t;

endpackage

/* File: core/sdc_disk_port.sv */
// Disk command port: command fetch, cycle steal transfer, arbiter
`timescale 1ns/1ns
module sdc_disk_port import sdc_pkg::*; (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         cmdStart,
    input  wire logic         devClear,
    output logic [7:0]        status,
    output logic              cmdDone,
    output logic              memReq,
    output logic              memWrite,
    output logic [15:0]       memAddr,
    output logic [7:0]        memWdata,
    input  wire logic [7:0]   memRdata,
    input  wire logic         memAck,
    input  wire logic [7:0]   extReq,
    output logic [7:0]        portGrant,
    input  wire logic [1:0]   jumperScheme,
    input  wire logic [3:0]   driveReadyPin,
    output logic [1:0]        diskDrive,
    output sdc_platter_t      diskPlatter,
    output logic [3:0]        diskOp,
    output logic              diskWrValid,
    output sdc_pbyte_t        diskWrByte,
    input  wire logic         diskWrReady,
    input  wire logic         diskRdValid,
    input  wire sdc_pbyte_t   diskRdByte,
    output logic              diskRdReady,
    input  wire logic         diskSectorBad,
    input  wire logic         diskSectorMissing
);

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_ARB, S_MEM, S_DISK, S_PROGL, S_PROGH, S_FIN
    } sdc_state_t;

    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    logic [5:0] pinMeta_q, pinSync_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= {jumperScheme, driveReadyPin};
            pinSync_q <= pinMeta_q;
        end
    end
    sdc_scheme_t scheme;
    logic [3:0]  driveReady;
    assign scheme     = sdc_scheme_t'(pinSync_q[5:4]);
    assign driveReady = pinSync_q[3:0];

    //------------------------------------------------------------------
    // Command sequencer
    //------------------------------------------------------------------
    sdc_state_t    st_q, st_d;
    logic [2:0]    step_q, step_d;
    logic [15:0]   org_q, org_d, end_q, end_d, cur_q, cur_d;
    logic [15:0]   addr_q, addr_d;
    logic [7:0]    mode_q, mode_d, wdat_q, wdat_d, stat_q, stat_d;
    logic          wrV_q, wrV_d, done_q, done_d;
    sdc_pbyte_t    wrB_q, wrB_d;
    logic [SECT_BYTES-1:0] ring_q, ring_d;
    logic [7:0]    sec_q, sec_d;
    logic          eRd_q, eRd_d, eSec_q, eSec_d, eNr_q, eNr_d;
    logic          ownReq;
    logic [3:0]    op;
    logic          isWr, isRd;

    assign op   = mode_q[3:0];
    assign isWr = (op == OP_WRITE);
    assign isRd = (op == OP_READ);

    always_comb begin
        st_d   = st_q;
        step_d = step_q;
        org_d  = org_q;
        end_d  = end_q;
        cur_d  = cur_q;
        addr_d = addr_q;
        mode_d = mode_q;
        wdat_d = wdat_q;
        stat_d = stat_q;
        wrV_d  = wrV_q;
        wrB_d  = wrB_q;
        ring_d = ring_q;
        sec_d  = sec_q;
        eRd_d  = eRd_q;
        eSec_d = eSec_q;
        eNr_d  = eNr_q;
        done_d = 1'b0;
        if (st_q != S_IDLE) begin
            eRd_d  = eRd_q | diskSectorBad;       // R19 R21
            eSec_d = eSec_q | diskSectorMissing;  // R23
        end
        case (st_q)
            S_IDLE: begin
                // Starts while busy are simply not seen here
                if (cmdStart) begin                       // R15
                    stat_d = '0;                          // R22
                    eRd_d  = 1'b0;
                    eSec_d = 1'b0;
                    eNr_d  = 1'b0;
                    step_d = '0;
                    addr_d = ADDR_ORIGIN_LO;              // R11
                    st_d   = S_FETCH;
                end
            end
            S_FETCH: begin
                if (memAck) begin
                    step_d = step_q + 3'h1;
                    case (step_q)
                        3'h0: begin
                            org_d[7:0] = memRdata;
                            addr_d     = ADDR_ORIGIN_HI;
                        end
                        3'h1: begin
                            org_d[15:8] = memRdata;
                            addr_d      = ADDR_END_LO;
                        end
                        3'h2: begin
                            end_d[7:0] = memRdata;
                            addr_d     = ADDR_END_HI;
                        end
                        3'h3: begin
                            end_d[15:8] = memRdata;
                            addr_d      = org_q + OFS_MODE;
                        end
                        default: begin
                            mode_d = memRdata;
                            cur_d  = org_q + OFS_DATA;    // R12 R13
                            ring_d = '0;
                            ring_d[0] = 1'b1;             // R7
                            sec_d  = '0;
                            if (!driveReady[memRdata[DRV_HI:DRV_LO]]) begin
                                eNr_d = 1'b1;             // R17
                                st_d  = S_FIN;
                            end else if (memRdata[3:0] == OP_READ ||
                                         memRdata[3:0] == OP_WRITE ||
                                         memRdata[3:0] == OP_VERIFY) begin
                                st_d = S_ARB;
                            end else begin
                                st_d = S_FIN;
                            end
                        end
                    endcase
                end
            end
            S_ARB: begin
                if (portGrant[OWN_PORT]) begin
                    addr_d = cur_q;
                    st_d   = isWr ? S_MEM : S_DISK;
                end
            end
            S_MEM: begin
                if (memAck) begin                         // R10
                    if (isWr) begin
                        wrB_d = '{par: ~^memRdata, data: memRdata}; // R5
                        wrV_d = 1'b1;             // R20
                        st_d  = S_DISK;
                    end else begin
                        addr_d = ADDR_PROG_LO;
                        wdat_d = cur_q[7:0];
                        st_d   = S_PROGL;
                    end
                end
            end
            S_DISK: begin
                if (isWr && wrV_q && diskWrReady) begin
                    // Recheck after the buffer register: catches a bad lane
                    if (!(^wrB_q)) begin
                        eSec_d = 1'b1;                    // R5 R9
                    end
                    wrV_d  = 1'b0;
                    addr_d = ADDR_PROG_LO;
                    wdat_d = cur_q[7:0];
                    st_d   = S_PROGL;
                end else if (!isWr && diskRdValid) begin
                    if (!(^diskRdByte)) begin
                        eRd_d = 1'b1;                     // R6 R9
                    end
                    wdat_d = diskRdByte.data;
                    if (isRd) begin
                        addr_d = cur_q;
                        st_d   = S_MEM;
                    end else begin
                        addr_d = ADDR_PROG_LO;            // R21
                        wdat_d = cur_q[7:0];
                        st_d   = S_PROGL;
                    end
                end
            end
            S_PROGL: begin
                if (memAck) begin
                    addr_d = ADDR_PROG_HI;                // R13
                    wdat_d = cur_q[15:8];
                    st_d   = S_PROGH;
                end
            end
            S_PROGH: begin
                if (memAck) begin
                    ring_d = {ring_q[SECT_BYTES-2:0],
                              ring_q[SECT_BYTES-1]};      // R7
                    sec_d  = sec_q + 8'h01;
                    if (sec_q == SECT_LAST && !ring_d[0]) begin
                        eSec_d = 1'b1;                    // R8 R9
                    end
                    if (cur_q == end_q) begin
                        st_d = S_FIN;                     // R14
                    end else begin
                        cur_d  = cur_q + 16'h0001;
                        addr_d = cur_q + 16'h0001;
                        st_d   = isWr ? S_MEM : S_DISK;
                    end
                end
            end
            S_FIN: begin
                stat_d[ST_IDLE]   = 1'b1;                 // R22
                stat_d[ST_SECTOR] = eSec_q;               // R23
                stat_d[ST_ADDR]   = eSec_q;               // R23
                stat_d[ST_READ]   = eRd_q & !isWr;        // R24
                stat_d[ST_NRDY]   = eNr_q;                // R17
                done_d = 1'b1;                            // R10
                st_d   = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
        if (devClear) begin
            st_d   = S_IDLE;
            stat_d = STATUS_RESET;                        // R22
            wrV_d  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= S_IDLE;
            step_q <= '0;
            org_q  <= '0;
            end_q  <= '0;
            cur_q  <= '0;
            addr_q <= '0;
            mode_q <= '0;
            wdat_q <= '0;
            stat_q <= STATUS_RESET;
            wrV_q  <= 1'b0;
            wrB_q  <= '0;
            ring_q <= '0;
            sec_q  <= '0;
            eRd_q  <= 1'b0;
            eSec_q <= 1'b0;
            eNr_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            step_q <= step_d;
            org_q  <= org_d;
            end_q  <= end_d;
            cur_q  <= cur_d;
            addr_q <= addr_d;
            mode_q <= mode_d;
            wdat_q <= wdat_d;
            stat_q <= stat_d;
            wrV_q  <= wrV_d;
            wrB_q  <= wrB_d;
            ring_q <= ring_d;
            sec_q  <= sec_d;
            eRd_q  <= eRd_d;
            eSec_q <= eSec_d;
            eNr_q  <= eNr_d;
            done_q <= done_d;
        end
    end

    assign memReq = (st_q == S_FETCH) || (st_q == S_PROGL) ||
                    (st_q == S_PROGH) || (st_q == S_MEM);
    assign memWrite    = (st_q == S_PROGL) || (st_q == S_PROGH) ||
                         (st_q == S_MEM && isRd);
    assign memAddr     = addr_q;
    assign memWdata    = wdat_q;
    assign status      = stat_q;
    assign cmdDone     = done_q;
    assign diskDrive   = mode_q[DRV_HI:DRV_LO];                  // R16
    assign diskPlatter = sdc_platter_t'(mode_q[PLT_HI:PLT_LO]);  // R18
    assign diskOp      = op;
    assign diskWrValid = wrV_q;
    assign diskWrByte  = wrB_q;
    assign diskRdReady = (st_q == S_DISK) && !isWr;
    // Held from arbitration to the end so the grant spans the command
    assign ownReq = (st_q == S_ARB) || (st_q == S_MEM) ||
                    (st_q == S_DISK) || (st_q == S_PROGL) ||
                    (st_q == S_PROGH);

    //------------------------------------------------------------------
    // Port arbiter
    //------------------------------------------------------------------
    logic [NPORT-1:0] req, gnt_q, gnt_d;
    logic [2:0]       ptr_q, ptr_d, idx, win, base;
    logic             found;

    always_comb begin
        req = extReq;                                     // R1
        req[OWN_PORT] = req[OWN_PORT] | ownReq;
        gnt_d = gnt_q;
        ptr_d = ptr_q;
        found = 1'b0;
        win   = '0;
        idx   = '0;
        base  = (scheme == SCH_FIXED) ? 3'h0 : ptr_q;     // R4
        if ((gnt_q & req) == '0) begin                    // R25
            gnt_d = '0;
            if (scheme == SCH_MODIFIED && req[0]) begin
                found = 1'b1;                             // R3
            end
            for (int i = 0; i < NPORT; i++) begin
                idx = base + i[2:0];
                if (!found && req[idx] &&
                    !(scheme == SCH_MODIFIED && idx == 3'h0)) begin
                    found = 1'b1;                         // R2 R3
                    win   = idx;
                end
            end
            if (found) begin
                gnt_d[win] = 1'b1;
                if (scheme == SCH_MODIFIED) begin
                    if (win != 3'h0) begin
                        ptr_d = (win == 3'h7) ? 3'h1 : win + 3'h1;
                    end
                end else begin
                    ptr_d = win + 3'h1;                   // R2
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gnt_q <= '0;
            ptr_q <= 3'h1;
        end else begin
            gnt_q <= gnt_d;
            ptr_q <= ptr_d;
        end
    end

    assign portGrant = gnt_q;

endmodule // sdc_disk_port

/* File: bench/sdc_disk_port_assertions.sv */
// Port checks for the shared disk command port
`timescale 1ns/1ns
module sdc_disk_port_assertions import sdc_pkg::*; (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cmdStart,
    input wire logic        devClear,
    input wire logic [7:0]  status,
    input wire logic        cmdDone,
    input wire logic        memReq,
    input wire logic        memAck,
    input wire logic [15:0] memAddr,
    input wire logic [7:0]  extReq,
    input wire logic [7:0]  portGrant,
    input wire logic        diskWrValid,
    input wire sdc_pbyte_t  diskWrByte,
    input wire logic        diskWrReady
);
    // ----------
    // Checks
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_grant_onehot: assert property ($onehot0(portGrant))
        else $error("several ports granted");
    chk_grant_kept: assert property (
        (portGrant & extReq) != 8'h00 && !devClear
        |=> portGrant == $past(portGrant))
        else $error("grant moved while still requested");
    chk_start_busy: assert property (
        status[ST_IDLE] && cmdStart && !devClear |=> status == 8'h00)
        else $error("start did not clear status");
    chk_first_fetch: assert property (
        $fell(status[ST_IDLE]) |-> memReq && memAddr == ADDR_ORIGIN_LO)
        else $error("command block not fetched first");
    chk_clear_idle: assert property (
        devClear |=> status == STATUS_RESET)
        else $error("clear did not return to idle");
    chk_done_once: assert property (
        cmdDone |-> status[ST_IDLE] ##1 !cmdDone)
        else $error("done is not a single idle pulse");
    chk_sector_pair: assert property (
        status[ST_SECTOR] |-> status[ST_ADDR])
        else $error("sector flag without address flag");
    chk_steal_hold: assert property (
        memReq && !memAck && !devClear |=> memReq && $stable(memAddr))
        else $error("memory request dropped early");
    chk_wr_parity: assert property (
        diskWrValid |-> ^diskWrByte)
        else $error("write byte parity not odd");
    chk_wr_hold: assert property (
        diskWrValid && !diskWrReady && !devClear
        |=> diskWrValid && $stable(diskWrByte))
        else $error("write byte changed before taken");

    cover property (cmdDone && status[ST_READ]);
    cover property (cmdDone && status[ST_SECTOR]);
    cover property (diskWrValid && !diskWrReady);
endmodule // sdc_disk_port_assertions

bind sdc_disk_port sdc_disk_port_assertions sdc_disk_port_assertions_inst (
    .clk, .rst, .cmdStart, .devClear, .status, .cmdDone, .memReq,
    .memAck, .memAddr, .extReq, .portGrant, .diskWrValid, .diskWrByte,
    .diskWrReady
);

/* File: bench/sdc_far_model.sv */
// Far side model: cycle-steal memory and disk data channel
`timescale 1ns/1ns
module sdc_far_model import sdc_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        badPar,
    input  wire logic        missEn,
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWdata,
    output logic [7:0]       memRdata,
    output logic             memAck,
    input  wire logic        diskWrValid,
    input  wire sdc_pbyte_t  diskWrByte,
    output logic             diskWrReady,
    output logic             diskRdValid,
    output sdc_pbyte_t       diskRdByte,
    input  wire logic        diskRdReady,
    output logic             diskSectorBad,
    output logic             diskSectorMissing
);
    // ----------
    // Memory and disk
    // ----------
    logic [7:0] mem [0:65535];
    sdc_pbyte_t wrLog [0:15];
    int         wrCnt;
    int         rdCnt;
    logic [1:0] waitQ;
    logic [7:0] rdData;

    assign rdData = 8'hA0 + rdCnt[7:0];
    // Idle lines show the inverse so stale data never looks valid
    assign diskRdByte = diskRdValid ? {~^rdData ^ badPar, rdData}
                                    : {1'b1, ~rdData};
    assign diskSectorMissing = missEn && diskWrValid && diskWrReady;
    assign diskSectorBad = missEn && diskRdValid && diskRdReady;

    always @(posedge clk) begin
        if (rst) begin
            memAck <= 1'b0;
            waitQ <= 2'h0;
            wrCnt <= 0;
            rdCnt <= 0;
            diskWrReady <= 1'b0;
            diskRdValid <= 1'b0;
            memRdata <= 8'h00;
        end else begin
            waitQ <= (memReq && !memAck) ? waitQ + 2'h1 : 2'h0;
            memAck <= memReq && !memAck && (!slow || waitQ == 2'h2);
            memRdata <= (memReq && !memAck) ? mem[memAddr] : ~memRdata;
            if (memAck && memReq && memWrite)
                mem[memAddr] <= memWdata;
            // Slow mode drops write ready every other cycle and drops read valid for one cycle after each byte taken
            diskWrReady <= slow ? !diskWrReady : 1'b1;
            diskRdValid <= !slow || !(diskRdValid && diskRdReady);
            if (diskWrValid && diskWrReady) begin
                wrLog[wrCnt[3:0]] <= diskWrByte;
                wrCnt <= wrCnt + 1;
            end
            if (diskRdValid && diskRdReady)
                rdCnt <= rdCnt + 1;
        end
    end
endmodule // sdc_far_model

/* File: bench/testbench.sv */
// Self-checking bench for the shared disk command port
`timescale 1ns/1ns
module testbench import sdc_pkg::*;;
    logic         clk, rst, cmdStart, devClear, cmdDone, memReq, diskSectorBad;
    logic         memWrite, memAck, diskWrValid, diskWrReady, diskRdValid;
    logic         diskRdReady, diskSectorMissing, slow, badPar, missEn;
    logic [7:0]   status, memWdata, memRdata, extReq, portGrant;
    logic [15:0]  memAddr;
    logic [1:0]   jumperScheme, diskDrive;
    logic [3:0]   driveReadyPin, diskOp;
    sdc_platter_t diskPlatter;
    sdc_pbyte_t   diskWrByte, diskRdByte;
    int           errors, cmpCount;

    sdc_disk_port sdc_disk_port_inst (
        .clk, .rst, .cmdStart, .devClear, .status, .cmdDone, .memReq,
        .memWrite, .memAddr, .memWdata, .memRdata, .memAck, .extReq,
        .portGrant, .jumperScheme, .driveReadyPin, .diskDrive,
        .diskPlatter, .diskOp, .diskWrValid, .diskWrByte, .diskWrReady,
        .diskRdValid, .diskRdByte, .diskRdReady, .diskSectorBad,
        .diskSectorMissing
    );
    sdc_far_model sdc_far_model_inst (
        .clk, .rst, .slow, .badPar, .missEn, .memReq, .memWrite, .memAddr,
        .memWdata, .memRdata, .memAck, .diskWrValid, .diskWrByte,
        .diskWrReady, .diskRdValid, .diskRdByte, .diskRdReady,
        .diskSectorBad, .diskSectorMissing
    );

    // ----------
    // Helpers
    // ----------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [7:0] mv(input logic [15:0] a);
        return sdc_far_model_inst.mem[a];
    endfunction

    task automatic mw(input logic [15:0] a, input logic [7:0] d);
        sdc_far_model_inst.mem[a] = d;
    endtask

    task automatic arb(input logic [7:0] req, input logic [7:0] exp);
        @(posedge clk) extReq <= req;
        repeat (4) @(negedge clk);
        check(portGrant, exp);
    endtask

    // Jumpers pass a two-stage synchroniser before they count
    task automatic scheme(input logic [1:0] s);
        @(posedge clk) jumperScheme <= s;
        repeat (3) @(posedge clk);
    endtask

    task automatic run_cmd(input logic [7:0] mode, input logic [15:0] org,
        input logic [15:0] fin, input logic [7:0] expSt, input logic abort);
        int n;
        mw(ADDR_ORIGIN_LO, org[7:0]);
        mw(ADDR_ORIGIN_HI, org[15:8]);
        mw(ADDR_END_LO, fin[7:0]);
        mw(ADDR_END_HI, fin[15:8]);
        mw(org + OFS_MODE, mode);
        @(posedge clk) cmdStart <= 1'b1;
        @(posedge clk) cmdStart <= 1'b0;
        if (abort) begin
            repeat (30) @(posedge clk);
            devClear <= 1'b1;
            @(posedge clk) devClear <= 1'b0;
            @(negedge clk);
            check(status, STATUS_RESET);
            return;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmdDone !== 1'b1 && n < 4000);
        check(cmdDone, 1'b1);
        check(status, expSt);
        check(diskDrive, mode[7:6]);
        check(diskPlatter, mode[5:4]);
        check(diskOp, mode[3:0]);
        if (!expSt[ST_NRDY])
            check({mv(ADDR_PROG_HI), mv(ADDR_PROG_LO)}, fin);
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_arb;
        check(status, STATUS_RESET);
        arb(8'h06, 8'h02);
        arb(8'h00, 8'h00);
        arb(8'h06, 8'h04);
        arb(8'h00, 8'h00);
        arb(8'h03, 8'h01);
        arb(8'h00, 8'h00);
        scheme(2'h1);
        arb(8'h83, 8'h01);
        arb(8'h00, 8'h00);
        scheme(2'h2);
        arb(8'h84, 8'h04);
        arb(8'h86, 8'h04);
        arb(8'h82, 8'h02);
        arb(8'h00, 8'h00);
        scheme(2'h0);
        $display("arbitration test done");
    endtask

    task automatic t_xfer;
        logic [7:0] d;
        slow <= 1'b1;
        mw(16'h2003, 8'h5A);
        run_cmd({2'b10, 2'b00, OP_READ}, 16'h2000, 16'h2005, 8'h80, 0);
        check(mv(16'h2003), 8'h5A);
        check(mv(16'h2004), 8'hA0);
        check(mv(16'h2005), 8'hA1);
        for (int i = 0; i < 256; i++)
            mw(16'h1004 + i, 8'h3C + i[7:0]);
        run_cmd({2'b01, 2'b10, OP_WRITE}, 16'h1000, 16'h1007, 8'h80, 0);
        check(sdc_far_model_inst.wrCnt[15:0], 16'h0004);
        for (int i = 0; i < 4; i++) begin
            d = 8'h3C + i[7:0];
            check(sdc_far_model_inst.wrLog[i], {~^d, d});
        end
        mw(16'h3004, 8'h5A);
        run_cmd({2'b00, 2'b11, OP_VERIFY}, 16'h3000, 16'h3004, 8'h80, 0);
        check(mv(16'h3004), 8'h5A);
        slow = 1'b0;
        $display("transfer test done");
    endtask

    task automatic t_errors;
        badPar = 1'b1;
        run_cmd({2'b10, 2'b01, OP_READ}, 16'h2100, 16'h2104, 8'hA0, 0);
        run_cmd({2'b01, 2'b01, OP_VERIFY}, 16'h3100, 16'h3104, 8'hA0, 0);
        badPar = 1'b0;
        missEn = 1'b1;
        run_cmd({2'b00, 2'b00, OP_WRITE}, 16'h1000, 16'h1005, 8'hD0, 0);
        run_cmd({2'b01, 2'b00, OP_READ}, 16'h2200, 16'h2204, 8'hA0, 0);
        missEn = 1'b0;
        run_cmd({2'b11, 2'b00, OP_READ}, 16'h2000, 16'h2005, 8'h82, 0);
        slow = 1'b1;
        run_cmd({2'b00, 2'b00, OP_WRITE}, 16'h1000, 16'h10FF, 8'h80, 1);
        slow = 1'b0;
        run_cmd({2'b00, 2'b00, OP_WRITE}, 16'h1000, 16'h1103, 8'h80, 0);
        run_cmd({2'b00, 2'b00, 4'h9}, 16'h1000, 16'h1103, 8'h80, 0);
        $display("error test done");
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        // Tests need a few thousand cycles; this leaves wide margin
        #400_000;
        errors++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        cmdStart = 1'b0;
        devClear = 1'b0;
        extReq = 8'h00;
        jumperScheme = 2'h0;
        driveReadyPin = 4'h7;
        slow = 1'b0;
        badPar = 1'b0;
        missEn = 1'b0;
        errors = 0;
        cmpCount = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        t_arb();
        t_xfer();
        t_errors();
        tally_and_finish();
    end
endmodule // testbench
